// ==== logic/dtcr_sampler.sv ====
// Samples the external inputs on the basic clock enable.
// Assumes pins already synchronous to sys_clk.
`timescale 1ns/1ps
module dtcr_sampler (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// Basic clock enable
	input  wire logic                sample_en,
	// Pins
	input  wire dtcr_pkg::dtcr_pins_t pins,
	// Sampled levels and changes
	output dtcr_pkg::dtcr_pins_t     level,
	output dtcr_pkg::dtcr_pins_t     rise,
	output dtcr_pkg::dtcr_pins_t     fall
);
	dtcr_pkg::dtcr_pins_t prev_reg;
	dtcr_pkg::dtcr_pins_t cur_reg;

	// Two consecutive samples taken on the basic clock
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prev_reg <= '0;
			cur_reg  <= '0;
		end else if (sample_en) begin
			prev_reg <= cur_reg;
			cur_reg  <= pins;
		end
	end

	// A change needs two samples that differ, one pulse per sample
	assign level = cur_reg;
	assign rise  = sample_en ? (cur_reg & ~prev_reg) : '0;
	assign fall  = sample_en ? (~cur_reg & prev_reg) : '0;
endmodule // dtcr_sampler

// ==== logic/dtcr_top.sv ====
// Dual timer with capture/reload: core timer, aux timer, capture register.
// Assumes synchronous pins and a one-cycle strobe register port.
`timescale 1ns/1ps
module dtcr_top (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	// Register port
	input  wire dtcr_pkg::dtcr_bus_t  bus,
	output logic [15:0]               rdata,
	// External inputs
	input  wire dtcr_pkg::dtcr_pins_t pins,
	// Outputs
	output logic                      core_toggle_pin,
	output logic                      core_toggle_pin_oe,
	output logic                      aux_irq,
	output logic                      core_irq,
	output logic                      capture_irq
);
	logic [15:0] core_ctrl_reg;
	logic [15:0] aux_ctrl_reg;
	logic [15:0] core_timer_reg;
	logic [15:0] aux_timer_reg;
	logic [15:0] capture_reload_reg;
	logic [2:0]  irq_flag_reg;
	logic [2:0]  irq_en_reg;
	logic [3:0]  bps_cnt_reg;
	logic [9:0]  core_pre_reg;
	logic [9:0]  aux_pre_reg;
	logic        basic_en;
	logic [3:0]  bps_div;
	dtcr_pkg::dtcr_pins_t lvl, rise, fall;
	logic        wr_core_ctrl, wr_aux_ctrl, wr_irq;
	logic        wr_core_cnt, wr_aux_cnt, wr_capture_reload_reg;
	logic        core_tick, aux_tick, core_down, aux_down;
	logic        core_wrap, aux_wrap, cap_evt;
	dtcr_pkg::dtcr_mode_t core_mode, aux_mode;
	dtcr_pkg::dtcr_edge_t cap_sel;

	// Prescaler and tick for one timer
	function automatic logic pre_tick(input logic [9:0] pre,
	                                  input logic [2:0] sel);
		logic [9:0] mask;
		mask = 10'((11'h1 << sel) - 11'h1);
		return (pre & mask) == mask;
	endfunction

	// Mode gating of a timer tick
	function automatic logic mode_tick(input dtcr_pkg::dtcr_mode_t m,
	                                   input logic pre_ok, input logic gate,
	                                   input logic cnt_ok);
		logic t;
		t = 1'b0;
		case (m)
			dtcr_pkg::DTCR_MODE_TIMER:  t = pre_ok;
			dtcr_pkg::DTCR_MODE_COUNT:  t = cnt_ok;
			dtcr_pkg::DTCR_MODE_GATE_L: t = pre_ok & ~gate;
			dtcr_pkg::DTCR_MODE_GATE_H: t = pre_ok & gate;
			default:                    t = 1'b0; // Reserved codes hold
		endcase
		return t;
	endfunction

	// Counter edge selected by input select (1 rise, 2 fall, 3 any)
	function automatic logic cnt_edge(input logic [2:0] sel,
	                                  input logic r, input logic f);
		return (sel[0] & r) | (sel[1] & f);
	endfunction

	// Address decode
	assign wr_core_ctrl = bus.wr && bus.addr == dtcr_pkg::OFS_CORE_CTRL;
	assign wr_aux_ctrl  = bus.wr && bus.addr == dtcr_pkg::OFS_AUX_CTRL;
	assign wr_irq       = bus.wr && bus.addr == dtcr_pkg::OFS_IRQ;
	assign wr_core_cnt  = bus.wr && bus.addr == dtcr_pkg::OFS_CORE_COUNT;
	assign wr_aux_cnt   = bus.wr && bus.addr == dtcr_pkg::OFS_AUX_COUNT;
	assign wr_capture_reload_reg    = bus.wr && bus.addr == dtcr_pkg::OFS_CAP_RELOAD;

	// Block prescaler divide selection, non-linear encoding
	always_comb begin
		case (core_ctrl_reg[dtcr_pkg::POS_BPS_LO +: 2])
			2'b00:   bps_div = dtcr_pkg::BPS_DIV4;
			2'b01:   bps_div = dtcr_pkg::BPS_DIV2;
			2'b10:   bps_div = dtcr_pkg::BPS_DIV16;
			default: bps_div = dtcr_pkg::BPS_DIV8;
		endcase
	end

	// Basic clock divider, one-cycle enable
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bps_cnt_reg <= 4'h0;
		end else if (bps_cnt_reg >= bps_div) begin
			bps_cnt_reg <= 4'h0;
		end else begin
			bps_cnt_reg <= bps_cnt_reg + 4'h1;
		end
	end
	assign basic_en = (bps_cnt_reg >= bps_div);

	// Input sampling on the basic clock
	dtcr_sampler u_sampler (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.sample_en (basic_en),
		.pins      (pins),
		.level     (lvl),
		.rise      (rise),
		.fall      (fall)
	);

	// Field views
	assign core_mode = dtcr_pkg::dtcr_mode_t'(core_ctrl_reg[5:3]);
	assign aux_mode  = dtcr_pkg::dtcr_mode_t'({1'b0, aux_ctrl_reg[4:3]});
	assign cap_sel   = dtcr_pkg::dtcr_edge_t'(
		aux_ctrl_reg[dtcr_pkg::POS_AUX_CE +: 2]);

	// Direction: external pin only when enabled
	assign core_down = core_ctrl_reg[dtcr_pkg::POS_EXTDIR] ?
		lvl.ext_dir : core_ctrl_reg[dtcr_pkg::POS_DIR];
	assign aux_down  = aux_ctrl_reg[dtcr_pkg::POS_AUX_DIR];

	// Count ticks gated by run bits and modes
	assign core_tick = basic_en && core_ctrl_reg[dtcr_pkg::POS_RUN] &&
		mode_tick(core_mode, pre_tick(core_pre_reg, core_ctrl_reg[2:0]),
		lvl.gate_in, cnt_edge(core_ctrl_reg[2:0], rise.count_in,
		fall.count_in));
	assign aux_tick = basic_en && aux_ctrl_reg[dtcr_pkg::POS_AUX_RUN] &&
		mode_tick(aux_mode, pre_tick(aux_pre_reg, aux_ctrl_reg[2:0]),
		lvl.gate_in, cnt_edge(aux_ctrl_reg[2:0], rise.count_in,
		fall.count_in));

	// Wrap detection
	assign core_wrap = core_tick && (core_down ? core_timer_reg == 16'h0000 :
		core_timer_reg == 16'hffff);
	assign aux_wrap = aux_tick && (aux_down ? aux_timer_reg == 16'h0000 :
		aux_timer_reg == 16'hffff);

	// Capture event on selected edge
	assign cap_evt = (cap_sel[0] & rise.capture) |
		(cap_sel[1] & fall.capture);

	// Core input prescaler on the basic clock
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			core_pre_reg <= 10'h000;
		end else if (basic_en) begin
			core_pre_reg <= core_pre_reg + 10'h001;
		end
	end

	// Aux input prescaler, free running so a new select takes at once
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aux_pre_reg <= 10'h000;
		end else if (basic_en) begin
			aux_pre_reg <= aux_pre_reg + 10'h001;
		end
	end

	// Core control register with toggle latch
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			core_ctrl_reg <= dtcr_pkg::RST_CORE_CTRL;
		end else if (wr_core_ctrl) begin
			core_ctrl_reg <= bus.wdata & dtcr_pkg::CORE_CTRL_MASK;
		end else if (core_wrap) begin
			core_ctrl_reg[dtcr_pkg::POS_TOGGLE] <=
				~core_ctrl_reg[dtcr_pkg::POS_TOGGLE];
		end
	end

	// Aux control register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aux_ctrl_reg <= dtcr_pkg::RST_AUX_CTRL;
		end else if (wr_aux_ctrl) begin
			aux_ctrl_reg <= bus.wdata & dtcr_pkg::AUX_CTRL_MASK;
		end
	end

	// Core timer: write, clear on capture, reload, count
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			core_timer_reg <= dtcr_pkg::RST_COUNT;
		end else if (wr_core_cnt) begin
			core_timer_reg <= bus.wdata;
		end else if (cap_evt && core_ctrl_reg[dtcr_pkg::POS_CLR_CAP]) begin
			core_timer_reg <= 16'h0000;
		end else if (core_wrap && core_ctrl_reg[dtcr_pkg::POS_RELOAD]) begin
			core_timer_reg <= capture_reload_reg;
		end else if (core_tick) begin
			core_timer_reg <= core_down ? core_timer_reg - 16'h0001 :
				core_timer_reg + 16'h0001;
		end
	end

	// Aux timer: write, count
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aux_timer_reg <= dtcr_pkg::RST_COUNT;
		end else if (wr_aux_cnt) begin
			aux_timer_reg <= bus.wdata;
		end else if (aux_tick) begin
			aux_timer_reg <= aux_down ? aux_timer_reg - 16'h0001 :
				aux_timer_reg + 16'h0001;
		end
	end

	// Capture/reload register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			capture_reload_reg <= dtcr_pkg::RST_COUNT;
		end else if (wr_capture_reload_reg) begin
			capture_reload_reg <= bus.wdata;
		end else if (cap_evt && aux_ctrl_reg[dtcr_pkg::POS_AUX_CAPT]) begin
			capture_reload_reg <= aux_timer_reg;
		end
	end

	// Request flags, set wins over a software clear; write 1 clears
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_flag_reg <= 3'h0;
		end else begin
			irq_flag_reg <= (irq_flag_reg & ~(wr_irq ? bus.wdata[2:0] : 3'h0))
				| {cap_evt, core_wrap, aux_wrap};
		end
	end

	// Interrupt enables, written in the same access as the flag clears
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_en_reg <= 3'h0;
		end else if (wr_irq) begin
			irq_en_reg <= bus.wdata[dtcr_pkg::POS_IEN_LO +: 3];
		end
	end

	// Interrupt lines, registered so they lag their flags one cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aux_irq     <= 1'b0;
			core_irq    <= 1'b0;
			capture_irq <= 1'b0;
		end else begin
			aux_irq     <= irq_flag_reg[0] & irq_en_reg[0];
			core_irq    <= irq_flag_reg[1] & irq_en_reg[1];
			capture_irq <= irq_flag_reg[2] & irq_en_reg[2];
		end
	end

	// Toggle output, held low while its enable is off
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			core_toggle_pin    <= 1'b0;
			core_toggle_pin_oe <= 1'b0;
		end else begin
			core_toggle_pin <= core_ctrl_reg[dtcr_pkg::POS_OUTEN] &
				core_ctrl_reg[dtcr_pkg::POS_TOGGLE];
			core_toggle_pin_oe <= core_ctrl_reg[dtcr_pkg::POS_OUTEN];
		end
	end

	// Read data one cycle after the read strobe, zero otherwise
	always_ff @(posedge sys_clk) begin
		if (rst || !bus.rd) begin
			rdata <= 16'h0000;
		end else if (bus.addr == dtcr_pkg::OFS_CORE_CTRL) begin
			rdata <= core_ctrl_reg;
		end else if (bus.addr == dtcr_pkg::OFS_CAP_RELOAD) begin
			rdata <= capture_reload_reg;
		end else if (bus.addr == dtcr_pkg::OFS_AUX_CTRL) begin
			rdata <= aux_ctrl_reg;
		end else if (bus.addr == dtcr_pkg::OFS_IRQ) begin
			rdata <= {9'h000, irq_en_reg, 1'b0, irq_flag_reg};
		end else if (bus.addr == dtcr_pkg::OFS_AUX_COUNT) begin
			rdata <= aux_timer_reg;
		end else if (bus.addr == dtcr_pkg::OFS_CORE_COUNT) begin
			rdata <= core_timer_reg;
		end else begin
			rdata <= 16'h0000;
		end
	end
endmodule // dtcr_top

// ==== shared/dtcr_pkg.sv ====
// Package for the dual timer with capture/reload block.
// Assumes a single 200 MHz clock and a plain register port.
package dtcr_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CORE_CTRL  = 8'h18;
	localparam logic [7:0] OFS_CAP_RELOAD = 8'h1c;
	localparam logic [7:0] OFS_AUX_CTRL   = 8'h20;
	localparam logic [7:0] OFS_IRQ        = 8'h24;
	localparam logic [7:0] OFS_AUX_COUNT  = 8'h2c;
	localparam logic [7:0] OFS_CORE_COUNT = 8'h30;
	// Reset values
	localparam logic [15:0] RST_CORE_CTRL = 16'h0000;
	localparam logic [15:0] RST_COUNT     = 16'h0000;
	localparam logic [15:0] RST_AUX_CTRL  = 16'h0000;
	// Core control field positions
	localparam int POS_RUN     = 6;
	localparam int POS_DIR     = 7;
	localparam int POS_EXTDIR  = 8;
	localparam int POS_OUTEN   = 9;
	localparam int POS_TOGGLE  = 10;
	localparam int POS_BPS_LO  = 11;
	localparam int POS_CLR_CAP = 14;
	localparam int POS_RELOAD  = 15;
	// Writable mask of core control (bit 13 reserved)
	localparam logic [15:0] CORE_CTRL_MASK = 16'hdfff;
	// Aux control positions (own layout)
	localparam int POS_AUX_RUN  = 6;
	localparam int POS_AUX_DIR  = 7;
	localparam int POS_AUX_CAPT = 15;
	localparam int POS_AUX_CE   = 12;
	localparam logic [15:0] AUX_CTRL_MASK = 16'hb0ff;
	// Irq register positions
	localparam int POS_IRQ_AUX  = 0;
	localparam int POS_IRQ_CORE = 1;
	localparam int POS_IRQ_CAP  = 2;
	localparam int POS_IEN_LO   = 4;
	// Block prescaler divide-1 values
	localparam logic [3:0] BPS_DIV4  = 4'h3;
	localparam logic [3:0] BPS_DIV2  = 4'h1;
	localparam logic [3:0] BPS_DIV16 = 4'hf;
	localparam logic [3:0] BPS_DIV8  = 4'h7;
	// Timer modes
	typedef enum logic [2:0] {
		DTCR_MODE_TIMER  = 3'b000,
		DTCR_MODE_COUNT  = 3'b001,
		DTCR_MODE_GATE_L = 3'b010,
		DTCR_MODE_GATE_H = 3'b011
	} dtcr_mode_t;
	// Capture edge select
	typedef enum logic [1:0] {
		DTCR_CAP_OFF  = 2'b00,
		DTCR_CAP_RISE = 2'b01,
		DTCR_CAP_FALL = 2'b10,
		DTCR_CAP_ANY  = 2'b11
	} dtcr_edge_t;
	// Sampled external inputs
	typedef struct packed {
		logic count_in;
		logic gate_in;
		logic ext_dir;
		logic capture;
	} dtcr_pins_t;
	// Register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} dtcr_bus_t;
endpackage

// ==== verif/dtcr_assertions.sv ====
// Port-level checks of the dual timer block.
// Assumes one-cycle register strobes and outputs lagging flags one cycle.
`timescale 1ns/1ps
module dtcr_checker (
	// Clock and reset
	input wire logic                 sys_clk,
	input wire logic                 rst,
	// Register port
	input wire dtcr_pkg::dtcr_bus_t  bus,
	input wire logic [15:0]          rdata,
	// Pins and outputs
	input wire dtcr_pkg::dtcr_pins_t pins,
	input wire logic                 core_toggle_pin,
	input wire logic                 core_toggle_pin_oe,
	input wire logic                 aux_irq,
	input wire logic                 core_irq,
	input wire logic                 capture_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Read data only in the slot after a read
	AST_RDATA_IDLE: assert property (
		!$past(bus.rd) |-> rdata == 16'h0000) else $error("stray read data");
	AST_UNMAPPED: assert property (
		$past(bus.rd) && !($past(bus.addr) inside
		{8'h18, 8'h1c, 8'h20, 8'h24, 8'h2c, 8'h30}) |-> rdata == 16'h0000)
		else $error("unmapped read not zero");
	AST_RES13: assert property (
		$past(bus.rd) && $past(bus.addr) == 8'h18 |-> !rdata[13])
		else $error("reserved control bit set");
	AST_CTRL_BACK: assert property (
		bus.wr && bus.addr == 8'h18 ##1 bus.rd && bus.addr == 8'h18 |=>
		(rdata & 16'hdbff) == ($past(bus.wdata, 2) & 16'hdbff))
		else $error("control readback differs");
	// Toggle output follows its control bits
	AST_OE_WRITE: assert property (
		bus.wr && bus.addr == 8'h18 |-> ##2
		core_toggle_pin_oe == $past(bus.wdata[9], 2))
		else $error("toggle enable wrong");
	AST_PIN_LATCH: assert property (
		bus.wr && bus.addr == 8'h18 && !bus.wdata[6] |-> ##2 core_toggle_pin
		== ($past(bus.wdata[9], 2) & $past(bus.wdata[10], 2)))
		else $error("toggle pin wrong");
	// Interrupt lines gated by enables, dropped only by writes
	AST_IRQ_MASK: assert property (
		bus.wr && bus.addr == 8'h24 |-> ##2 ({capture_irq, core_irq,
		aux_irq} & ~$past(bus.wdata[6:4], 2)) == 3'b000)
		else $error("masked interrupt seen");
	AST_IRQ_FALL: assert property (
		$fell(core_irq) || $fell(aux_irq) || $fell(capture_irq) |->
		$past(bus.wr, 2) && $past(bus.addr, 2) == 8'h24)
		else $error("interrupt dropped alone");
	COV_CORE: cover property ($rose(core_irq));
	COV_AUX: cover property ($rose(aux_irq));
	COV_CAP: cover property ($rose(capture_irq));
endmodule // dtcr_checker

bind dtcr_top dtcr_checker u_chk (.sys_clk, .rst, .bus, .rdata, .pins,
	.core_toggle_pin, .core_toggle_pin_oe, .aux_irq, .core_irq, .capture_irq);

// ==== verif/dtcr_bench.sv ====
// Self-checking bench for the dual timer with capture/reload.
// Assumes a 200 MHz clock and the pin model on the external inputs.
`timescale 1ns/1ps
module dtcr_bench;
	logic                 sys_clk;
	logic                 rst;
	dtcr_pkg::dtcr_bus_t  bus;
	logic [15:0]          rdata;
	dtcr_pkg::dtcr_pins_t want;
	dtcr_pkg::dtcr_pins_t pins;
	logic                 core_toggle_pin, core_toggle_pin_oe;
	logic                 aux_irq, core_irq, capture_irq;
	wire  [2:0]           irqs = {capture_irq, core_irq, aux_irq};
	int                   mismatches = 0, total_checks = 0, cycles = 0, i;
	logic [15:0]          rv;
	logic [7:0]           ofs [5] = '{8'h18, 8'h1c, 8'h2c, 8'h30, 8'h04};
	// Control word, pin levels, expected count change
	logic [35:0] tb [10] = '{36'h0040_0_0010, 36'h0840_2_0020,
		36'h1040_0_0004, 36'h18c0_0_fff8, 36'h0940_2_ffe0, 36'h0940_0_0020,
		36'h0841_0_0010, 36'h0800_0_0000, 36'h0850_4_0000, 36'h0858_4_0020};

	dtcr_top DUT (.sys_clk, .rst, .bus, .rdata, .pins, .core_toggle_pin,
		.core_toggle_pin_oe, .aux_irq, .core_irq, .capture_irq);
	dtcr_pin_model u_pins (.sys_clk, .rst, .want, .pins);

	// Clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			mismatches++;
			summarize();
		end
	end

	// Register port tasks and comparison
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk);
		bus <= '0;
		@(posedge sys_clk);
	endtask
	task automatic bus_rd(input logic [7:0] a);
		bus <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge sys_clk);
		bus <= '0;
		#1;
		rv = rdata;
		@(posedge sys_clk);
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
		bus_rd(a);
		chk(rv, exp);
	endtask
	task automatic wait_irq(input int b);
		for (int n = 0; n < 200 && irqs[b] !== 1'b1; n++)
			@(posedge sys_clk);
		chk({15'h0, irqs[b]}, 16'h0001);
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Test sequence
	initial begin
		rst = 1'b1;
		bus = '0;
		want = '0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		foreach (ofs[k]) rdchk(ofs[k], 16'h0000);
		for (i = 1; i < 4; i++) begin
			bus_wr(ofs[i], 16'ha5c3);
			rdchk(ofs[i], 16'ha5c3);
		end
		// Control write straight into a read
		bus <= '{1'b1, 1'b0, 8'h18, 16'hffff};
		@(posedge sys_clk);
		bus <= '{1'b0, 1'b1, 8'h18, 16'h0000};
		@(posedge sys_clk);
		bus <= '0;
		#1;
		chk(rdata, 16'hdfff);
		@(posedge sys_clk);
		chk({14'h0, core_toggle_pin, core_toggle_pin_oe}, 16'h0003);
		bus_wr(8'h18, 16'h0200);
		rdchk(8'h18, 16'h0200);
		chk({14'h0, core_toggle_pin, core_toggle_pin_oe}, 16'h0001);
		// Up wrap sets the flag and flips the latch
		bus_wr(8'h30, 16'hfffd);
		bus_wr(8'h24, 16'h0070);
		bus_wr(8'h18, 16'h0840);
		wait_irq(1);
		rdchk(8'h18, 16'h0c40);
		bus_wr(8'h18, 16'h0000);
		bus_wr(8'h24, 16'h0000);
		rdchk(8'h24, 16'h0002);
		chk({13'h0, irqs}, 16'h0000);
		bus_wr(8'h24, 16'h0007);
		rdchk(8'h24, 16'h0000);
		// Rate, direction, gate and run per table entry
		for (i = 0; i < 10; i++) begin
			want <= tb[i][19:16];
			repeat (45) @(posedge sys_clk);
			bus_wr(8'h30, 16'h8000);
			bus_wr(8'h18, tb[i][35:20]);
			repeat (62) @(posedge sys_clk);
			bus_wr(8'h18, 16'h0000);
			bus_rd(8'h30);
			rv = rv - 16'h8000 - tb[i][15:0] + 16'h0002;
			chk({15'h0, rv <= 16'h0004}, 16'h0001);
		end
		// Wrap reloads from the capture/reload value
		bus_wr(8'h1c, 16'h1000);
		bus_wr(8'h30, 16'hfffe);
		bus_wr(8'h18, 16'h8840);
		repeat (40) @(posedge sys_clk);
		bus_wr(8'h18, 16'h0000);
		bus_rd(8'h30);
		chk({15'h0, rv - 16'h1000 <= 16'h0020}, 16'h0001);
		// Counter mode counts rising count-input edges
		bus_wr(8'h30, 16'h8000);
		bus_wr(8'h18, 16'h0849);
		for (i = 0; i < 5; i++) begin
			want <= 4'h8;
			repeat (45) @(posedge sys_clk);
			want <= 4'h0;
			repeat (45) @(posedge sys_clk);
		end
		bus_wr(8'h18, 16'h0000);
		rdchk(8'h30, 16'h8005);
		// Aux wrap, then a falling capture edge clears the core
		bus_wr(8'h30, 16'h1234);
		bus_wr(8'h2c, 16'hfffd);
		bus_wr(8'h18, 16'h4000);
		bus_wr(8'h24, 16'h0050);
		bus_wr(8'h20, 16'ha040);
		wait_irq(0);
		bus_wr(8'h20, 16'ha000);
		bus_wr(8'h2c, 16'h5a5a);
		want <= 4'h1;
		repeat (60) @(posedge sys_clk);
		chk({15'h0, capture_irq}, 16'h0000);
		want <= 4'h0;
		wait_irq(2);
		rdchk(8'h30, 16'h0000);
		rdchk(8'h1c, 16'h5a5a);
		summarize();
	end
endmodule // dtcr_bench

// ==== verif/dtcr_pin_model.sv ====
// Sources of the count, gate, direction and capture inputs.
// Assumes the bench requests levels; each level stands at least HOLD+1 cycles.
`timescale 1ns/1ps
module dtcr_pin_model #(
	parameter int HOLD = 40
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	// Requested and driven levels
	input  wire dtcr_pkg::dtcr_pins_t want,
	output dtcr_pkg::dtcr_pins_t      pins
);
	dtcr_pkg::dtcr_pins_t lvl_reg = '0;
	int                   held_reg = 0;
	assign pins = lvl_reg;
	// Change only after the present level stood a full hold time
	always @(posedge sys_clk) begin
		if (rst) begin
			lvl_reg <= '0;
			held_reg <= 0;
		end else if (held_reg >= HOLD && want != lvl_reg) begin
			lvl_reg <= want;
			held_reg <= 0;
		end else if (held_reg < HOLD) begin
			held_reg <= held_reg + 1;
		end
	end
endmodule // dtcr_pin_model
